// >>> src/uic_pkg.sv
// constants, types and helpers for the universal input counter block
// assumes one 250 MHz clock and a byte-level link from a serial receiver
package uic_pkg;
  localparam int NUM_INPUTS = 4;
  localparam int CLK_HZ = 250_000_000;
  localparam int SAMPLE_MS = 10;
  localparam int SAMPLE_CYCLES = CLK_HZ / 1000 * SAMPLE_MS;
  localparam logic [7:0] SERVER_ADDR = 8'hc8;
  localparam logic [7:0] FC_READ = 8'h03;
  localparam logic [7:0] FC_WRITE = 8'h06;
  localparam logic [7:0] FC_EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_VALUE = 8'h03;
  localparam logic [3:0] REQ_LEN = 4'h8;
  localparam logic [7:0] POS_ADDR = 8'h00;
  localparam logic [7:0] POS_FC = 8'h01;
  localparam logic [7:0] POS_CNT = 8'h02;
  localparam logic [7:0] RSP_HDR_LEN = 8'h03;
  localparam logic [7:0] CRC_LEN = 8'h02;
  localparam logic [7:0] ECHO_LEN = 8'h08;
  localparam logic [7:0] EXC_LEN = 8'h05;
  localparam logic [15:0] MAX_READ_QTY = 16'h0010;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam logic [15:0] VALUE_BASE = 16'h0001;
  localparam logic [15:0] CFG_BASE = 16'h0cea;
  localparam logic [15:0] CNT_BASE = 16'h132c;
  localparam logic [15:0] IN_STRIDE = 16'h0014;
  localparam logic [15:0] OFS_TYPE = 16'h0000;
  localparam logic [15:0] OFS_UNIT = 16'h0001;
  localparam logic [15:0] OFS_FS = 16'h0002;
  localparam logic [15:0] OFS_THR = 16'h0003;
  localparam logic [15:0] OFS_HYS = 16'h0004;
  localparam logic [15:0] OFS_RISE = 16'h0000;
  localparam logic [15:0] OFS_FALL = 16'h0001;
  localparam logic [15:0] OFS_CNT_HI = 16'h0002;
  localparam logic [15:0] OFS_CNT_LO = 16'h0003;
  localparam logic [3:0] TYPE_SINK = 4'h0;
  localparam logic [3:0] TYPE_SOURCE = 4'h1;
  localparam logic [3:0] TYPE_MA = 4'h2;
  localparam logic [3:0] TYPE_VOLT = 4'h3;
  localparam logic [3:0] TYPE_THERM = 4'h4;
  localparam logic [3:0] TYPE_UNUSED5 = 4'h5;
  localparam logic [3:0] TYPE_UNUSED6 = 4'h6;
  localparam logic [3:0] TYPE_BRIDGE = 4'h7;
  localparam logic [3:0] TYPE_FAST = 4'h8;
  localparam logic [3:0] TYPE_RESET = TYPE_FAST;
  localparam logic [15:0] FLAG_MAX = 16'h0001;
  // thermistor values are signed tenths of a degree
  localparam int F_MUL = 9;
  localparam int F_DIV = 5;
  localparam int F_OFFSET = 320;

  typedef enum logic [3:0] {
    FLD_NONE, FLD_VALUE, FLD_TYPE, FLD_UNIT, FLD_FS, FLD_THR, FLD_HYS,
    FLD_RISE, FLD_FALL, FLD_CNT_HI, FLD_CNT_LO
  } uic_field_e;

  typedef enum logic [1:0] {KIND_READ, KIND_ECHO, KIND_EXC} uic_kind_e;

  function automatic logic [15:0] uic_crc_byte(input logic [15:0] crc,
                                               input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int k = 0; k < 8; k++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction
endpackage

// >>> src/uic_counter.sv
// one input's sampled transition counter
// assumes level already synchronised and tick a one-cycle 10 ms enable
`timescale 1ns/1ps
module uic_counter (
  input wire logic clk, // system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic tick, // sample enable pulse
  input wire logic level, // synchronised input level
  input wire logic count_en, // input type allows counting
  input wire logic rise_en, // count low-to-high changes
  input wire logic fall_en, // count high-to-low changes
  output logic [31:0] count, // running transition count
  output logic sample // last sampled level
);
  logic sample_q;
  logic [31:0] count_q;
  logic rise_w;
  logic fall_w;
  logic hit_w;

  // compare successive samples, no edge detector on the raw pin
  assign rise_w = level & ~sample_q;
  assign fall_w = ~level & sample_q;
  assign hit_w = tick & count_en &
                 ((rise_en & rise_w) | (fall_en & fall_w));

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sample_q <= 1'b0;
      count_q <= 32'h0000_0000;
    end else begin
      if (tick) sample_q <= level;
      if (hit_w) count_q <= count_q + 32'h0000_0001;
    end
  end

  assign count = count_q;
  assign sample = sample_q;
endmodule

// >>> src/uic_top.sv
// universal input unit: four inputs, sampled counters, bus server
// assumes a serial front end delivering request bytes and an end-of-frame
// pulse, and taking response bytes with a valid/ready handshake
`timescale 1ns/1ps
module uic_top #(
  parameter int SAMPLE_CYCLES_P = uic_pkg::SAMPLE_CYCLES // 10 ms in clocks
) (
  input wire logic clk, // 250 MHz system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic [uic_pkg::NUM_INPUTS-1:0] in_level, // input pins, async
  input wire logic [uic_pkg::NUM_INPUTS*16-1:0] analog_value, // converter
  input wire logic rx_valid, // request byte strobe
  input wire logic [7:0] rx_data, // request byte
  input wire logic rx_frame_end, // line silence after a frame
  output logic tx_valid, // response byte valid
  output logic [7:0] tx_data, // response byte
  input wire logic tx_ready, // front end takes the byte
  output logic [uic_pkg::NUM_INPUTS*4-1:0] in_type, // type per input
  output logic [uic_pkg::NUM_INPUTS-1:0] temp_fahrenheit, // unit select
  output logic [uic_pkg::NUM_INPUTS-1:0] full_scale_en, // full scale
  output logic [uic_pkg::NUM_INPUTS*16-1:0] threshold, // threshold
  output logic [uic_pkg::NUM_INPUTS*16-1:0] hysteresis, // hysteresis
  output logic [uic_pkg::NUM_INPUTS-1:0] analog_cfg_en, // analog type
  output logic [uic_pkg::NUM_INPUTS-1:0] long_settle // slow settling
);
  import uic_pkg::*;

  localparam int TW = $clog2(SAMPLE_CYCLES_P + 1);

  typedef enum {ST_RECV, ST_EXEC, ST_SEND} uic_state_e;

  uic_state_e state_q;
  logic [NUM_INPUTS-1:0] lvl_meta_q;
  logic [NUM_INPUTS-1:0] lvl_sync_q;
  logic [TW-1:0] tick_cnt_q;
  logic tick_w;
  logic [3:0] type_q [NUM_INPUTS];
  logic unit_q [NUM_INPUTS];
  logic fs_q [NUM_INPUTS];
  logic [15:0] thr_q [NUM_INPUTS];
  logic [15:0] hys_q [NUM_INPUTS];
  logic rise_q [NUM_INPUTS];
  logic fall_q [NUM_INPUTS];
  logic [31:0] cnt_w [NUM_INPUTS];
  logic [31:0] snap_q [NUM_INPUTS];
  logic smp_w [NUM_INPUTS];
  logic [15:0] value_w [NUM_INPUTS];
  logic [7:0] rxb_q [REQ_LEN];
  logic [3:0] rx_cnt_q;
  logic [15:0] rx_crc_q;
  logic rx_ovf_q;
  uic_kind_e kind_q;
  logic [7:0] exc_q;
  logic [7:0] fc_q;
  logic [15:0] rd_base_q;
  logic [7:0] tx_len_q;
  logic [7:0] tx_idx_q;
  logic [15:0] tx_crc_q;
  logic tx_valid_q;
  logic [7:0] tx_data_q;

  // one tick every sample period
  assign tick_w = tick_cnt_q == TW'(SAMPLE_CYCLES_P - 1);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tick_cnt_q <= '0;
      lvl_meta_q <= '0;
      lvl_sync_q <= '0;
    end else begin
      tick_cnt_q <= tick_w ? '0 : tick_cnt_q + TW'(1);
      lvl_meta_q <= in_level;
      lvl_sync_q <= lvl_meta_q;
    end
  end

  // address to {input, field}
  function automatic logic [5:0] reg_decode(input logic [15:0] a);
    logic [5:0] r;
    logic [15:0] cb;
    logic [15:0] kb;
    logic [1:0] ix;
    r = {2'h0, FLD_NONE};
    for (int i = 0; i < NUM_INPUTS; i++) begin
      cb = CFG_BASE + 16'(i) * IN_STRIDE;
      kb = CNT_BASE + 16'(i) * IN_STRIDE;
      ix = 2'(i);
      if (a == VALUE_BASE + 16'(i)) r = {ix, FLD_VALUE};
      if (a == cb + OFS_TYPE) r = {ix, FLD_TYPE};
      if (a == cb + OFS_UNIT) r = {ix, FLD_UNIT};
      if (a == cb + OFS_FS) r = {ix, FLD_FS};
      if (a == cb + OFS_THR) r = {ix, FLD_THR};
      if (a == cb + OFS_HYS) r = {ix, FLD_HYS};
      if (a == kb + OFS_RISE) r = {ix, FLD_RISE};
      if (a == kb + OFS_FALL) r = {ix, FLD_FALL};
      if (a == kb + OFS_CNT_HI) r = {ix, FLD_CNT_HI};
      if (a == kb + OFS_CNT_LO) r = {ix, FLD_CNT_LO};
    end
    return r;
  endfunction

  function automatic logic [15:0] rd_word(input logic [15:0] a);
    logic [5:0] d;
    logic [1:0] i;
    logic [15:0] v;
    d = reg_decode(a);
    i = d[5:4];
    case (uic_field_e'(d[3:0]))
      FLD_VALUE: v = value_w[i];
      FLD_TYPE: v = {12'h000, type_q[i]};
      FLD_UNIT: v = {15'h0000, unit_q[i]};
      FLD_FS: v = {15'h0000, fs_q[i]};
      FLD_THR: v = thr_q[i];
      FLD_HYS: v = hys_q[i];
      FLD_RISE: v = {15'h0000, rise_q[i]};
      FLD_FALL: v = {15'h0000, fall_q[i]};
      FLD_CNT_HI: v = snap_q[i][31:16];
      FLD_CNT_LO: v = snap_q[i][15:0];
      default: v = 16'h0000;
    endcase
    return v;
  endfunction

  genvar g;
  generate
    for (g = 0; g < NUM_INPUTS; g++) begin : g_in
      logic discrete_w;
      logic therm_w;
      logic [15:0] raw_w;
      logic [15:0] fahr_w;
      assign discrete_w = type_q[g] == TYPE_SINK ||
                          type_q[g] == TYPE_SOURCE ||
                          type_q[g] == TYPE_FAST;
      assign therm_w = type_q[g] == TYPE_THERM;
      assign raw_w = analog_value[g*16 +: 16];
      assign fahr_w = 16'((32'(signed'(raw_w)) * F_MUL) / F_DIV
                          + F_OFFSET);
      assign value_w[g] = discrete_w ? {15'h0000, smp_w[g]} :
                          (therm_w && unit_q[g]) ? fahr_w :
                          (type_q[g] == TYPE_BRIDGE ||
                           type_q[g] == TYPE_UNUSED5 ||
                           type_q[g] == TYPE_UNUSED6) ? 16'h0000 :
                          raw_w;
      uic_counter u_cnt (
        .clk(clk),
        .rst_n(rst_n),
        .tick(tick_w),
        .level(lvl_sync_q[g]),
        .count_en(discrete_w),
        .rise_en(rise_q[g]),
        .fall_en(fall_q[g]),
        .count(cnt_w[g]),
        .sample(smp_w[g])
      );
      assign in_type[g*4 +: 4] = type_q[g];
      assign temp_fahrenheit[g] = unit_q[g];
      assign full_scale_en[g] = fs_q[g];
      assign threshold[g*16 +: 16] = thr_q[g];
      assign hysteresis[g*16 +: 16] = hys_q[g];
      assign analog_cfg_en[g] = type_q[g] == TYPE_MA ||
                                type_q[g] == TYPE_VOLT || therm_w;
      assign long_settle[g] = type_q[g] == TYPE_SINK;
    end
  endgenerate

  // request decode
  logic [7:0] req_fc_w;
  logic [15:0] req_reg_w;
  logic [15:0] req_val_w;
  logic req_ok_w;
  logic [5:0] wr_dec_w;
  uic_field_e wr_fld_w;
  logic [1:0] wr_idx_w;
  logic rd_qty_ok_w;
  logic rd_addr_ok_w;
  logic wr_addr_ok_w;
  logic wr_val_ok_w;
  logic [7:0] exc_w;

  assign req_fc_w = rxb_q[1];
  assign req_reg_w = {rxb_q[2], rxb_q[3]};
  assign req_val_w = {rxb_q[4], rxb_q[5]};
  assign req_ok_w = rx_cnt_q == REQ_LEN && !rx_ovf_q &&
                    rx_crc_q == 16'h0000 &&
                    rxb_q[0] == SERVER_ADDR;
  assign wr_dec_w = reg_decode(req_reg_w);
  assign wr_fld_w = uic_field_e'(wr_dec_w[3:0]);
  assign wr_idx_w = wr_dec_w[5:4];
  assign rd_qty_ok_w = req_val_w != 16'h0000 && req_val_w <= MAX_READ_QTY;
  assign rd_addr_ok_w = wr_fld_w != FLD_NONE &&
      reg_decode(req_reg_w + req_val_w - 16'h0001) != {2'h0, FLD_NONE};
  assign wr_addr_ok_w = wr_fld_w != FLD_NONE && wr_fld_w != FLD_VALUE &&
                        wr_fld_w != FLD_CNT_HI && wr_fld_w != FLD_CNT_LO;
  assign wr_val_ok_w = wr_fld_w == FLD_TYPE ?
      (req_val_w <= {12'h000, TYPE_FAST} &&
       req_val_w != {12'h000, TYPE_UNUSED5} &&
       req_val_w != {12'h000, TYPE_UNUSED6}) :
      (wr_fld_w == FLD_THR || wr_fld_w == FLD_HYS) ? 1'b1 :
      req_val_w <= FLAG_MAX;
  assign exc_w = (req_fc_w == FC_READ) ?
                   (!rd_qty_ok_w ? EXC_VALUE :
                    !rd_addr_ok_w ? EXC_ADDR : EXC_NONE) :
                 (req_fc_w == FC_WRITE) ?
                   (!wr_addr_ok_w ? EXC_ADDR :
                    !wr_val_ok_w ? EXC_VALUE : EXC_NONE) :
                 EXC_FUNC;

  // response byte at the current position
  logic [7:0] pos_w;
  logic [15:0] word_w;
  logic [7:0] byte_w;
  logic body_w;
  assign pos_w = tx_idx_q - RSP_HDR_LEN;
  // process form so the word follows the registers the function reads
  always_comb word_w = rd_word(rd_base_q + {9'h000, pos_w[7:1]});
  assign body_w = tx_idx_q < tx_len_q - CRC_LEN;

  always_comb begin
    byte_w = 8'h00;
    if (tx_idx_q == tx_len_q - CRC_LEN) begin
      byte_w = tx_crc_q[7:0];
    end else if (!body_w) begin
      byte_w = tx_crc_q[15:8];
    end else if (tx_idx_q == POS_ADDR) begin
      byte_w = SERVER_ADDR;
    end else if (tx_idx_q == POS_FC) begin
      byte_w = fc_q;
    end else begin
      case (kind_q)
        KIND_READ: byte_w = (tx_idx_q == POS_CNT) ? tx_len_q - EXC_LEN :
                            (pos_w[0] ? word_w[7:0] : word_w[15:8]);
        KIND_ECHO: byte_w = rxb_q[tx_idx_q[2:0]];
        KIND_EXC: byte_w = exc_q;
        default: byte_w = 8'h00;
      endcase
    end
  end

  logic load_w;
  assign load_w = state_q == ST_SEND && (!tx_valid_q || tx_ready);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= ST_RECV;
      rx_cnt_q <= 4'h0;
      rx_crc_q <= CRC_INIT;
      rx_ovf_q <= 1'b0;
      kind_q <= KIND_READ;
      exc_q <= EXC_NONE;
      fc_q <= 8'h00;
      rd_base_q <= 16'h0000;
      tx_len_q <= 8'h00;
      tx_idx_q <= 8'h00;
      tx_crc_q <= CRC_INIT;
      tx_valid_q <= 1'b0;
      tx_data_q <= 8'h00;
      for (int i = 0; i < REQ_LEN; i++) rxb_q[i] <= 8'h00;
      for (int i = 0; i < NUM_INPUTS; i++) snap_q[i] <= 32'h0000_0000;
    end else begin
      case (state_q)
        ST_RECV: begin
          if (rx_valid && rx_cnt_q < REQ_LEN) begin
            rxb_q[rx_cnt_q[2:0]] <= rx_data;
            rx_cnt_q <= rx_cnt_q + 4'h1;
            rx_crc_q <= uic_crc_byte(rx_crc_q, rx_data);
          end else if (rx_valid) begin
            rx_ovf_q <= 1'b1;
          end
          if (rx_frame_end) state_q <= ST_EXEC;
        end
        ST_EXEC: begin
          rx_cnt_q <= 4'h0;
          rx_crc_q <= CRC_INIT;
          rx_ovf_q <= 1'b0;
          state_q <= req_ok_w ? ST_SEND : ST_RECV;
          for (int i = 0; i < NUM_INPUTS; i++) snap_q[i] <= cnt_w[i];
          exc_q <= exc_w;
          rd_base_q <= req_reg_w;
          tx_idx_q <= 8'h00;
          tx_crc_q <= CRC_INIT;
          if (exc_w != EXC_NONE) begin
            kind_q <= KIND_EXC;
            fc_q <= req_fc_w | FC_EXC_FLAG;
            tx_len_q <= EXC_LEN;
          end else if (req_fc_w == FC_READ) begin
            kind_q <= KIND_READ;
            fc_q <= req_fc_w;
            tx_len_q <= EXC_LEN + {req_val_w[6:0], 1'b0};
          end else begin
            kind_q <= KIND_ECHO;
            fc_q <= req_fc_w;
            tx_len_q <= ECHO_LEN;
          end
        end
        ST_SEND: begin
          // one transaction in flight; request bytes arriving now are dropped, not kept
          if (load_w && tx_idx_q < tx_len_q) begin
            tx_data_q <= byte_w;
            tx_valid_q <= 1'b1;
            tx_idx_q <= tx_idx_q + 8'h01;
            if (body_w) tx_crc_q <= uic_crc_byte(tx_crc_q, byte_w);
          end else if (load_w) begin
            tx_valid_q <= 1'b0;
            state_q <= ST_RECV;
          end
        end
        default: state_q <= ST_RECV;
      endcase
    end
  end

  // configuration writes
  logic wr_go_w;
  assign wr_go_w = state_q == ST_EXEC && req_ok_w &&
                   req_fc_w == FC_WRITE && exc_w == EXC_NONE;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_INPUTS; i++) begin
        type_q[i] <= TYPE_RESET;
        unit_q[i] <= 1'b0;
        fs_q[i] <= 1'b0;
        thr_q[i] <= 16'h0000;
        hys_q[i] <= 16'h0000;
        rise_q[i] <= 1'b0;
        fall_q[i] <= 1'b0;
      end
    end else if (wr_go_w) begin
      case (wr_fld_w)
        FLD_TYPE: type_q[wr_idx_w] <= req_val_w[3:0];
        FLD_UNIT: unit_q[wr_idx_w] <= req_val_w[0];
        FLD_FS: fs_q[wr_idx_w] <= req_val_w[0];
        FLD_THR: thr_q[wr_idx_w] <= req_val_w;
        FLD_HYS: hys_q[wr_idx_w] <= req_val_w;
        FLD_RISE: rise_q[wr_idx_w] <= req_val_w[0];
        FLD_FALL: fall_q[wr_idx_w] <= req_val_w[0];
        default: ;
      endcase
    end
  end

  assign tx_valid = tx_valid_q;
  assign tx_data = tx_data_q;
endmodule

// >>> tb/uic_monitor.sv
// port-level checker for the universal input counter top
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
module uic_monitor #(
  parameter int SAMPLE_CYCLES_P = 20 // tick spacing in clocks
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic rx_frame_end, // frame silence pulse
  input wire logic tx_valid, // response byte valid
  input wire logic [7:0] tx_data, // response byte
  input wire logic tx_ready, // sink takes byte
  input wire logic [uic_pkg::NUM_INPUTS*4-1:0] in_type, // types
  input wire logic [uic_pkg::NUM_INPUTS-1:0] temp_fahrenheit, // unit
  input wire logic [uic_pkg::NUM_INPUTS*16-1:0] threshold, // thresholds
  input wire logic [uic_pkg::NUM_INPUTS-1:0] analog_cfg_en, // analog
  input wire logic [uic_pkg::NUM_INPUTS-1:0] long_settle // slow settle
);
  import uic_pkg::*;
  logic [NUM_INPUTS-1:0] settle_exp;
  logic [NUM_INPUTS-1:0] analog_exp;
  logic types_ok;
  always_comb begin
    types_ok = 1'b1;
    for (int i = 0; i < NUM_INPUTS; i++) begin
      settle_exp[i] = in_type[4*i+:4] == TYPE_SINK;
      analog_exp[i] = in_type[4*i+:4] inside {TYPE_MA, TYPE_VOLT, TYPE_THERM};
      if (in_type[4*i+:4] inside {TYPE_UNUSED5, TYPE_UNUSED6}) types_ok = 1'b0;
      if (in_type[4*i+:4] > TYPE_FAST) types_ok = 1'b0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // answer byte first seen three clocks after frame close
  sequence frame_close_s;
    rx_frame_end && !tx_valid ##3 $rose(tx_valid);
  endsequence
  reset_values_a: assert property ($rose(rst_n) |->
    !tx_valid && in_type == {NUM_INPUTS{TYPE_RESET}})
    else $error("outputs not at reset values");
  server_answer_a: assert property (frame_close_s |->
    tx_data == SERVER_ADDR) else $error("answer without server address");
  answer_cause_a: assert property ($rose(tx_valid) |->
    $past(rx_frame_end, 3)) else $error("answer without a closed frame");
  tx_hold_a: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_data)) else $error("response byte not held");
  settle_map_a: assert property (long_settle == settle_exp)
    else $error("settling select wrong");
  analog_map_a: assert property (analog_cfg_en == analog_exp)
    else $error("analog settings enable wrong");
  type_legal_a: assert property (types_ok)
    else $error("illegal input type held");
  cfg_write_a: assert property ($changed(in_type) ||
    $changed(temp_fahrenheit) || $changed(threshold) |->
    $past(rx_frame_end, 2)) else $error("config changed without request");
endmodule

bind uic_top uic_monitor #(.SAMPLE_CYCLES_P(SAMPLE_CYCLES_P)) u_mon (
  .clk(clk), .rst_n(rst_n), .rx_frame_end(rx_frame_end),
  .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
  .in_type(in_type), .temp_fahrenheit(temp_fahrenheit),
  .threshold(threshold), .analog_cfg_en(analog_cfg_en),
  .long_settle(long_settle));

// >>> tb/uic_client.sv
// processor-board client model: sends framed requests, takes responses
// assumes the bench calls xact only when no transaction is open
`timescale 1ns/1ps
module uic_client (
  input wire logic clk, // system clock
  output logic rx_valid, // request byte strobe
  output logic [7:0] rx_data, // request byte
  output logic rx_frame_end, // frame silence pulse
  input wire logic tx_valid, // response byte valid
  input wire logic [7:0] tx_data, // response byte
  output logic tx_ready // take response byte
);
  function automatic logic [15:0] crc16(input logic [15:0] c,
                                        input logic [7:0] b);
    c = c ^ {8'h00, b};
    for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    return c;
  endfunction
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_frame_end = 1'b0;
    tx_ready = 1'b0;
  end
  task automatic xact(input logic [47:0] pl, input bit bad, input bit slow,
                      output logic [7:0] rsp [10], output int n,
                      output bit ok);
    logic [15:0] c;
    logic [63:0] fr;
    int w;
    c = 16'hffff;
    for (int i = 5; i >= 0; i--) c = crc16(c, pl[8*i+:8]);
    fr = {pl, c[7:0] ^ {7'h00, bad}, c[15:8]};
    for (int i = 7; i >= 0; i--) begin
      rx_valid <= 1'b1;
      rx_data <= fr[8*i+:8];
      @(posedge clk);
    end
    rx_valid <= 1'b0;
    rx_data <= ~fr[7:0];
    rx_frame_end <= 1'b1;
    @(posedge clk);
    rx_frame_end <= 1'b0;
    n = 0;
    w = 0;
    c = 16'hffff;
    // quiet tail keeps requests a full tick apart
    while (w < 40) begin
      tx_ready <= slow ? ~tx_ready : 1'b1;
      @(posedge clk);
      w++;
      if (tx_valid && tx_ready) begin
        if (n < 10) rsp[n] = tx_data;
        c = crc16(c, tx_data);
        n++;
        w = 0;
      end
    end
    tx_ready <= 1'b0;
    ok = c == 16'h0000;
  endtask
endmodule

// >>> tb/universal_input_counter_test.sv
// self-checking bench for the universal input counter
// assumes the client model owns the request and response side
`timescale 1ns/1ps
module universal_input_counter_test;
  import uic_pkg::*;
  typedef struct packed {
    logic [47:0] pl;
    logic [7:0] len;
    logic [55:0] ex;
  } uic_row_s;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [NUM_INPUTS-1:0] in_level = '0;
  logic [NUM_INPUTS*16-1:0] analog_value = 64'h00fa_5555_beef_1234;
  logic rx_valid, rx_frame_end, tx_valid, tx_ready;
  logic [7:0] rx_data, tx_data;
  logic [15:0] in_type;
  logic [3:0] temp_fahrenheit, full_scale_en, analog_cfg_en, long_settle;
  logic [63:0] threshold, hysteresis;
  logic [7:0] rsp [10];
  int n;
  bit ok;
  int error_cnt = 0;
  int num_checks = 0;
  uic_row_s rows [16] = '{
    {48'hc8030cea0001, 8'd7, 56'hc8030200080000},
    {48'hc8060cfe0003, 8'd8, 56'hc8060cfe000300},
    {48'hc80300020001, 8'd7, 56'hc80302beef0000},
    {48'hc8060cea0005, 8'd5, 56'hc8860300000000},
    {48'hc8060d120007, 8'd8, 56'hc8060d12000700},
    {48'hc80300030001, 8'd7, 56'hc8030200000000},
    {48'hc806132e0001, 8'd5, 56'hc8860200000000},
    {48'hc80400010001, 8'd5, 56'hc8840100000000},
    {48'hc70300010001, 8'd0, 56'h0},
    {48'hc8060d260004, 8'd8, 56'hc8060d26000400},
    {48'hc8060d270001, 8'd8, 56'hc8060d27000100},
    {48'hc80300040001, 8'd7, 56'hc8030203020000},
    {48'hc80300010000, 8'd5, 56'hc8830300000000},
    {48'hc8060d280001, 8'd8, 56'hc8060d28000100},
    {48'hc8060d291234, 8'd8, 56'hc8060d29123400},
    {48'hc8060d2a0056, 8'd8, 56'hc8060d2a005600}};
  always #2 clk = ~clk;
  uic_top #(.SAMPLE_CYCLES_P(20)) DUT (
    .clk(clk), .rst_n(rst_n), .in_level(in_level),
    .analog_value(analog_value), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_frame_end(rx_frame_end), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .in_type(in_type),
    .temp_fahrenheit(temp_fahrenheit), .full_scale_en(full_scale_en),
    .threshold(threshold), .hysteresis(hysteresis),
    .analog_cfg_en(analog_cfg_en), .long_settle(long_settle));
  uic_client u_cli (
    .clk(clk), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_frame_end(rx_frame_end), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready));
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic run(input logic [47:0] pl, input int len,
                     input logic [55:0] ex, input bit bad = 1'b0,
                     input bit slow = 1'b0);
    u_cli.xact(pl, bad, slow, rsp, n, ok);
    chk("length", n, len);
    if (len > 0) chk("crc", {31'h0, ok}, 1);
    for (int i = 0; i < len - 2; i++) begin
      chk("byte", rsp[i], ex[55-8*i-:8]);
    end
  endtask
  // one full level period, each level held past a sample tick
  task automatic pulse;
    in_level[0] <= 1'b1;
    repeat (30) @(posedge clk);
    in_level[0] <= 1'b0;
    repeat (30) @(posedge clk);
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (10000) @(posedge clk);
    error_cnt++;
    end_sim;
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("reset type", in_type, 16'h8888);
    chk("reset settle", long_settle, 4'h0);
    foreach (rows[i]) run(rows[i].pl, rows[i].len, rows[i].ex);
    chk("types", in_type, 16'h4738);
    chk("analog en", analog_cfg_en, 4'ha);
    chk("unit", temp_fahrenheit, 4'h8);
    chk("full scale", full_scale_en, 4'h8);
    chk("threshold", threshold[63:48], 16'h1234);
    chk("hysteresis", hysteresis[63:48], 16'h0056);
    run(48'hc8030cea0001, 7, 56'hc8030200080000, 1'b0, 1'b1);
    run(48'hc8060cea0000, 0, 56'h0, 1'b1);
    chk("dropped write", in_type[3:0], 4'h8);
    run(48'hc806132c0001, 8, 56'hc806132c000100);
    repeat (3) pulse;
    run(48'hc803132e0002, 9, 56'hc8030400000003);
    run(48'hc806132d0001, 8, 56'hc806132d000100);
    repeat (2) pulse;
    run(48'hc803132e0002, 9, 56'hc8030400000007);
    run(48'hc8060cea0002, 8, 56'hc8060cea000200);
    repeat (2) pulse;
    run(48'hc803132e0002, 9, 56'hc8030400000007);
    run(48'hc8060cea0000, 8, 56'hc8060cea000000);
    chk("settle sink", long_settle, 4'h1);
    pulse;
    run(48'hc803132e0002, 9, 56'hc8030400000009);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    run(48'hc803132e0002, 9, 56'hc8030400000000);
    chk("type again", in_type, 16'h8888);
    end_sim;
  end
endmodule
